// ==== pwr_seq_pkg.sv ====
// Shared timing constants and types for the pushbutton power sequencer
package pwr_seq_pkg;

    // ==========================================================
    // Clock
    // ==========================================================
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CLK_KHZ = CLK_HZ / 1000;

    // ==========================================================
    // Times in their own units, as printed
    // ==========================================================
    localparam int unsigned RELEASE_DEBOUNCE_TIME_MS = 32;
    localparam int unsigned IRQ_MIN_WIDTH_MS = 32;
    localparam int unsigned RESTART_LOCKOUT_TIME_MS = 1000;
    localparam int unsigned KILL_MIN_PULSE_US = 30;
    localparam int unsigned KILL_RESPONSE_US = 15;
    localparam int unsigned HOLD_EXTENSION_TICKS = 16;

    // ==========================================================
    // Derived cycle counts (least times round up)
    // ==========================================================
    localparam int unsigned RELEASE_DEBOUNCE_CYC =
        RELEASE_DEBOUNCE_TIME_MS * CLK_KHZ;
    localparam int unsigned IRQ_MIN_WIDTH_CYC = IRQ_MIN_WIDTH_MS * CLK_KHZ;
    localparam int unsigned RESTART_LOCKOUT_CYC =
        RESTART_LOCKOUT_TIME_MS * CLK_KHZ;
    // Power-off request filter; shorter than the least acted-on pulse
    localparam int unsigned KILL_FILTER_CYC =
        (KILL_RESPONSE_US * CLK_HZ + 999_999) / 1_000_000;

    // ==========================================================
    // Widths and reset values
    // ==========================================================
    localparam int unsigned TIMER_W = 24;
    localparam int unsigned HOLD_W = 5;
    localparam int unsigned KILL_W = 8;
    localparam int unsigned SYNC_W = 6;
    localparam logic IRQ_N_RESET = 1'b1;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_LOCKOUT,
        ST_IDLE,
        ST_ON,
        ST_DEBOUNCE,
        ST_IRQ,
        ST_HOLD,
        ST_WAIT_REL
    } seq_state_t;

endpackage

// ==== pin_sync.sv ====
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pins and synchronised copies
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule
`default_nettype wire

// ==== pushbutton_power_sequencer.sv ====
// Pushbutton and supply-monitor driven power enable sequencer
`timescale 1ns/10ps
`default_nettype none
module pushbutton_power_sequencer #(
    parameter logic ACTIVE_LOW = 1'b0,
    parameter logic [23:0] DEBOUNCE_CYC =
        24'(pwr_seq_pkg::RELEASE_DEBOUNCE_CYC),
    parameter logic [23:0] IRQ_WIDTH_CYC =
        24'(pwr_seq_pkg::IRQ_MIN_WIDTH_CYC),
    parameter logic [23:0] LOCKOUT_CYC =
        24'(pwr_seq_pkg::RESTART_LOCKOUT_CYC)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pushbutton and supply monitor pins
    input wire logic pushButton_n,
    input wire logic supplyOn,
    input wire logic offArm,
    // Host power-off request, low active
    input wire logic powerOffReq_n,
    // Hold-extension oscillator and capacitor-fitted strap
    input wire logic holdDelayCap,
    input wire logic holdCapFitted,
    // Outputs
    output logic powerEnable,
    output logic irq_n
);

    // ==========================================================
    // State record
    // ==========================================================
    typedef struct packed {
        pwr_seq_pkg::seq_state_t state;
        logic [pwr_seq_pkg::TIMER_W-1:0] timer;
        logic [pwr_seq_pkg::HOLD_W-1:0] holdCnt;
        logic [pwr_seq_pkg::KILL_W-1:0] killCnt;
        logic byMonitor;
        logic srcButton;
        logic pbSeenHigh;
        logic onPrev;
        logic firstBoot;
        logic tickPrev;
        logic irqN;
        logic enPin;
    } seq_t;

    localparam seq_t SEQ_RESET = '{
        state: pwr_seq_pkg::ST_LOCKOUT,
        timer: '0,
        holdCnt: '0,
        killCnt: '0,
        byMonitor: 1'b0,
        srcButton: 1'b0,
        pbSeenHigh: 1'b0,
        onPrev: 1'b0,
        firstBoot: 1'b1,
        tickPrev: 1'b0,
        irqN: pwr_seq_pkg::IRQ_N_RESET,
        enPin: ACTIVE_LOW
    };

    localparam logic [pwr_seq_pkg::KILL_W-1:0] KILL_LAST =
        pwr_seq_pkg::KILL_W'(pwr_seq_pkg::KILL_FILTER_CYC - 1);
    localparam logic [pwr_seq_pkg::HOLD_W-1:0] HOLD_LAST =
        pwr_seq_pkg::HOLD_W'(pwr_seq_pkg::HOLD_EXTENSION_TICKS - 1);

    seq_t s_r;
    seq_t s_nxt;

    // ==========================================================
    // Pin synchronisation
    // ==========================================================
    logic [pwr_seq_pkg::SYNC_W-1:0] pinsIn;
    logic [pwr_seq_pkg::SYNC_W-1:0] pinsSync;
    logic pbLow;
    logic monHigh;
    logic armSync;
    logic killLow;
    logic oscSync;
    logic capSync;

    // Every pin is asynchronous to clk
    assign pinsIn = {holdCapFitted, holdDelayCap, powerOffReq_n, offArm,
                     supplyOn, pushButton_n};

    pin_sync #(
        .W(pwr_seq_pkg::SYNC_W)
    ) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .d(pinsIn),
        .q(pinsSync)
    );

    // Decoded synchronised levels
    assign pbLow = ~pinsSync[0];
    assign monHigh = pinsSync[1];
    assign armSync = pinsSync[2];
    assign killLow = ~pinsSync[3];
    assign oscSync = pinsSync[4];
    assign capSync = pinsSync[5];

    // ==========================================================
    // Derived events
    // ==========================================================
    logic killHit;
    logic holdTick;
    logic onRise;
    logic srcLow;
    logic isOn;

    // Request is acted on once it has stayed low the filter time
    assign killHit = killLow && (s_r.killCnt == KILL_LAST);
    // Extension oscillator edge, counted apart from the clock timer
    assign holdTick = oscSync & ~s_r.tickPrev;
    assign onRise = monHigh & ~s_r.onPrev;
    // Turn-off source still asserted
    assign srcLow = s_r.srcButton ? pbLow : ~monHigh;
    assign isOn = (s_r.state == pwr_seq_pkg::ST_ON) ||
                  (s_r.state == pwr_seq_pkg::ST_DEBOUNCE) ||
                  (s_r.state == pwr_seq_pkg::ST_IRQ) ||
                  (s_r.state == pwr_seq_pkg::ST_HOLD);

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        s_nxt = s_r;
        s_nxt.tickPrev = oscSync;
        // Rising edges of the monitor only count after the boot lockout
        if (!(s_r.state == pwr_seq_pkg::ST_LOCKOUT && s_r.firstBoot)) begin
            s_nxt.onPrev = monHigh;
        end
        // Low-time filter on the power-off request
        if (!killLow) begin
            s_nxt.killCnt = '0;
        end else if (s_r.killCnt != KILL_LAST) begin
            s_nxt.killCnt = s_r.killCnt + 1'b1;
        end
        if (isOn && killHit) begin
            // Host request ends power at once, from any on state
            s_nxt.state = pwr_seq_pkg::ST_WAIT_REL;
            s_nxt.enPin = ACTIVE_LOW;
            s_nxt.irqN = 1'b1;
            s_nxt.timer = '0;
        end else begin
            unique case (s_r.state)
                pwr_seq_pkg::ST_LOCKOUT: begin
                    // Inputs ignored for the lockout time
                    if (s_r.timer == LOCKOUT_CYC - 24'h000001) begin
                        s_nxt.state = pwr_seq_pkg::ST_IDLE;
                        s_nxt.firstBoot = 1'b0;
                        s_nxt.timer = '0;
                    end else begin
                        s_nxt.timer = s_r.timer + 1'b1;
                    end
                end
                pwr_seq_pkg::ST_IDLE: begin
                    // Button has priority over the monitor edge
                    if (pbLow) begin
                        s_nxt.state = pwr_seq_pkg::ST_ON;
                        s_nxt.enPin = ~ACTIVE_LOW;
                        s_nxt.byMonitor = 1'b0;
                        s_nxt.pbSeenHigh = 1'b0;
                    end else if (onRise) begin
                        s_nxt.state = pwr_seq_pkg::ST_ON;
                        s_nxt.enPin = ~ACTIVE_LOW;
                        s_nxt.byMonitor = 1'b1;
                        s_nxt.pbSeenHigh = 1'b1;
                    end
                end
                pwr_seq_pkg::ST_ON: begin
                    // The button must be seen released before a new press
                    if (!pbLow) begin
                        s_nxt.pbSeenHigh = 1'b1;
                    end
                    if (s_r.pbSeenHigh && pbLow) begin
                        s_nxt.state = pwr_seq_pkg::ST_DEBOUNCE;
                        s_nxt.timer = '0;
                    end else if (s_r.byMonitor && armSync && !monHigh) begin
                        // Monitor path raises the interrupt with no debounce
                        s_nxt.state = pwr_seq_pkg::ST_IRQ;
                        s_nxt.irqN = 1'b0;
                        s_nxt.srcButton = 1'b0;
                        s_nxt.timer = '0;
                    end
                end
                pwr_seq_pkg::ST_DEBOUNCE: begin
                    // Any release restarts the wait for a press
                    if (!pbLow) begin
                        s_nxt.state = pwr_seq_pkg::ST_ON;
                    end else if (s_r.timer == DEBOUNCE_CYC - 24'h000001) begin
                        s_nxt.state = pwr_seq_pkg::ST_IRQ;
                        s_nxt.irqN = 1'b0;
                        s_nxt.srcButton = 1'b1;
                        s_nxt.timer = '0;
                    end else begin
                        s_nxt.timer = s_r.timer + 1'b1;
                    end
                end
                pwr_seq_pkg::ST_IRQ: begin
                    // Interrupt holds low for its least width unless a host request ends power first
                    if (s_r.timer == IRQ_WIDTH_CYC - 24'h000001) begin
                        s_nxt.timer = '0;
                        if (!srcLow) begin
                            s_nxt.state = pwr_seq_pkg::ST_ON;
                            s_nxt.irqN = 1'b1;
                        end else if (capSync) begin
                            s_nxt.state = pwr_seq_pkg::ST_HOLD;
                            s_nxt.holdCnt = '0;
                        end else begin
                            // No extension: forced off right here
                            s_nxt.state = pwr_seq_pkg::ST_WAIT_REL;
                            s_nxt.enPin = ACTIVE_LOW;
                            s_nxt.irqN = 1'b1;
                        end
                    end else begin
                        s_nxt.timer = s_r.timer + 1'b1;
                    end
                end
                pwr_seq_pkg::ST_HOLD: begin
                    // Release during the extension aborts the turn-off
                    if (!srcLow) begin
                        s_nxt.state = pwr_seq_pkg::ST_ON;
                        s_nxt.irqN = 1'b1;
                    end else if (holdTick) begin
                        if (s_r.holdCnt == HOLD_LAST) begin
                            s_nxt.state = pwr_seq_pkg::ST_WAIT_REL;
                            s_nxt.enPin = ACTIVE_LOW;
                            s_nxt.irqN = 1'b1;
                        end else begin
                            s_nxt.holdCnt = s_r.holdCnt + 1'b1;
                        end
                    end
                end
                pwr_seq_pkg::ST_WAIT_REL: begin
                    // Lockout starts only once the button is up
                    if (!pbLow) begin
                        s_nxt.state = pwr_seq_pkg::ST_LOCKOUT;
                        s_nxt.timer = '0;
                    end
                end
                default: begin
                    s_nxt = SEQ_RESET;
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_r <= SEQ_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign powerEnable = s_r.enPin;
    assign irq_n = s_r.irqN;

endmodule
`default_nettype wire

// ==== pwr_seq_properties.sv ====
// Port-level assertions for the pushbutton power sequencer
`timescale 1ns/10ps
`default_nettype none
module pwr_seq_properties #(
    parameter logic ACTIVE_LOW = 1'b0,
    parameter logic [23:0] DEBOUNCE_CYC = 24'h000014,
    parameter logic [23:0] IRQ_WIDTH_CYC = 24'h000014,
    parameter logic [23:0] LOCKOUT_CYC = 24'h000032
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Watched pins
    input wire logic pushButton_n,
    input wire logic supplyOn,
    input wire logic offArm,
    input wire logic powerOffReq_n,
    input wire logic holdDelayCap,
    input wire logic holdCapFitted,
    input wire logic powerEnable,
    input wire logic irq_n
);
    typedef struct packed {
        logic [23:0] btnLow;
        logic [23:0] reqLow;
        logic [23:0] irqLow;
        logic [23:0] offCnt;
        logic [7:0] ticks;
        logic capPrev;
        logic monOn;
    } chk_t;
    chk_t c_r, c_nxt;
    logic isOn;
    assign isOn = (powerEnable != ACTIVE_LOW);
    // Run lengths of pin levels and oscillator ticks while interrupted;
    // every count sticks at its top, so full-length timings never wrap
    always_comb begin
        c_nxt = c_r;
        c_nxt.btnLow = pushButton_n ? 24'h0 :
            c_r.btnLow + {23'h0, ~&c_r.btnLow};
        c_nxt.reqLow = powerOffReq_n ? 24'h0 :
            c_r.reqLow + {23'h0, ~&c_r.reqLow};
        c_nxt.irqLow = irq_n ? 24'h0 : c_r.irqLow + {23'h0, ~&c_r.irqLow};
        c_nxt.offCnt = isOn ? 24'h0 : c_r.offCnt + {23'h0, ~&c_r.offCnt};
        c_nxt.ticks = irq_n ? 8'h0 :
            c_r.ticks + {7'h0, holdDelayCap & ~c_r.capPrev & ~&c_r.ticks};
        c_nxt.capPrev = holdDelayCap;
        if (isOn && c_r.offCnt != 24'h0) c_nxt.monOn = (c_r.btnLow == 24'h0);
        if (!reset_n) c_nxt = '0;
    end
    // Helper register
    always_ff @(posedge clk) c_r <= c_nxt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence forced_off_s;
        $past(isOn) && !isOn && !$past(irq_n) && c_r.reqLow < 24'h000080;
    endsequence
    a_reset_off_level: assert property (
        $rose(reset_n) |-> !isOn && irq_n) else $error("not off after reset");
    a_req_prompt: assert property (
        c_r.reqLow == 24'h0000AA |-> !isOn) else $error("request not obeyed");
    a_req_filter: assert property (
        $past(isOn) && !isOn && $past(irq_n) |-> c_r.reqLow >= 24'h00008C)
        else $error("turned off by short request");
    a_debounce_irq: assert property (
        $fell(irq_n) && !c_r.monOn |-> c_r.btnLow >= DEBOUNCE_CYC)
        else $error("interrupt before debounce");
    a_irq_min_width: assert property (
        $rose(irq_n) && c_r.reqLow < 24'h000080 |->
        c_r.irqLow >= IRQ_WIDTH_CYC) else $error("interrupt too short");
    a_forced_no_cap: assert property (
        forced_off_s and !holdCapFitted |-> c_r.irqLow inside
        {[IRQ_WIDTH_CYC : IRQ_WIDTH_CYC + 24'h2]}) else $error("forced time");
    a_hold_ticks: assert property (
        forced_off_s and holdCapFitted |-> c_r.ticks >= 8'h10)
        else $error("extension ended early");
    a_lockout_hold: assert property (
        $rose(isOn) |-> c_r.offCnt >= LOCKOUT_CYC)
        else $error("turned on inside lockout");
    a_monitor_irq: assert property (
        $fell(supplyOn) && offArm && c_r.monOn && isOn && irq_n |->
        ##[2:5] !irq_n) else $error("monitor fall not acted on");
    a_arm_ignore: assert property (
        $fell(supplyOn) && !offArm && isOn && irq_n && pushButton_n |->
        ##1 irq_n [*8]) else $error("unarmed monitor fall acted on");
endmodule
bind pushbutton_power_sequencer pwr_seq_properties #(
    .ACTIVE_LOW(ACTIVE_LOW), .DEBOUNCE_CYC(DEBOUNCE_CYC),
    .IRQ_WIDTH_CYC(IRQ_WIDTH_CYC), .LOCKOUT_CYC(LOCKOUT_CYC)
) chk (.clk(clk), .reset_n(reset_n), .pushButton_n(pushButton_n),
    .supplyOn(supplyOn), .offArm(offArm), .powerOffReq_n(powerOffReq_n),
    .holdDelayCap(holdDelayCap), .holdCapFitted(holdCapFitted),
    .powerEnable(powerEnable), .irq_n(irq_n));
`default_nettype wire

// ==== host_model.sv ====
// Host processor and timing oscillator on the far side of the sequencer
`timescale 1ns/10ps
`default_nettype none
module host_model (
    // Clock
    input wire logic clk,
    // Bench controls
    input wire logic respond,
    input wire logic oscEn,
    input wire logic glitch,
    // Device pins
    input wire logic irq_n,
    output logic powerOffReq_n,
    output logic holdDelayCap
);
    int cnt = 0;
    int osc = 0;
    logic busy = 1'b0;
    initial begin
        powerOffReq_n = 1'b1;
        holdDelayCap = 1'b0;
    end
    // Oscillator stands low when off; request after shutdown work
    always @(posedge clk) begin
        #20;
        osc = (osc + 1) % 4;
        if (!oscEn) holdDelayCap = 1'b0;
        else if (osc == 0) holdDelayCap = ~holdDelayCap;
        if (!busy && ((respond && !irq_n) || glitch)) begin
            busy = 1'b1;
            cnt = glitch ? 100 : 210;
        end else if (cnt > 0) cnt--;
        else if (irq_n) busy = 1'b0;
        powerOffReq_n = !(busy && cnt > 0 && cnt <= 200);
    end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the pushbutton power sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
    failures++; $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
    end end
module tb;
    localparam logic [23:0] DEB = 24'h000014;
    localparam logic [23:0] LOCK = 24'h000032;
    typedef struct {int press; logic cap; logic resp; logic expOn;} row_t;
    row_t rows[6] = '{'{10, 1'b0, 1'b0, 1'b1}, '{30, 1'b0, 1'b0, 1'b1},
        '{60, 1'b0, 1'b0, 1'b0}, '{60, 1'b1, 1'b0, 1'b1},
        '{250, 1'b1, 1'b0, 1'b0}, '{25, 1'b0, 1'b1, 1'b0}};
    logic clk, reset_n, pushButton_n, supplyOn, offArm, holdCapFitted;
    logic respond, oscEn, glitch, powerOffReq_n, holdDelayCap;
    logic enHi, enLo, irqHi, irqLo;
    int failures = 0;
    int cmp_count = 0;
    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // High-true and low-true variants on the same pins
    pushbutton_power_sequencer #(.ACTIVE_LOW(1'b0), .DEBOUNCE_CYC(DEB),
        .IRQ_WIDTH_CYC(DEB), .LOCKOUT_CYC(LOCK)) DUT (.clk(clk),
        .reset_n(reset_n), .pushButton_n(pushButton_n), .supplyOn(supplyOn),
        .offArm(offArm), .powerOffReq_n(powerOffReq_n),
        .holdDelayCap(holdDelayCap), .holdCapFitted(holdCapFitted),
        .powerEnable(enHi), .irq_n(irqHi));
    pushbutton_power_sequencer #(.ACTIVE_LOW(1'b1), .DEBOUNCE_CYC(DEB),
        .IRQ_WIDTH_CYC(DEB), .LOCKOUT_CYC(LOCK)) DUT_N (.clk(clk),
        .reset_n(reset_n), .pushButton_n(pushButton_n), .supplyOn(supplyOn),
        .offArm(offArm), .powerOffReq_n(powerOffReq_n),
        .holdDelayCap(holdDelayCap), .holdCapFitted(holdCapFitted),
        .powerEnable(enLo), .irq_n(irqLo));
    host_model host (.clk(clk), .respond(respond), .oscEn(oscEn),
        .glitch(glitch), .irq_n(irqHi), .powerOffReq_n(powerOffReq_n),
        .holdDelayCap(holdDelayCap));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic press(input int n);
        pushButton_n = 1'b0;
        cyc(n);
        pushButton_n = 1'b1;
    endtask
    task automatic chk_state(input logic expOn);
        `CHK(enHi, expOn)
        `CHK(enLo, ~expOn)
        `CHK(irqHi, 1'b1)
        `CHK(irqLo, 1'b1)
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Watchdog against a hung sequence
    initial begin
        cyc(20000);
        failures++;
        close_out();
    end
    // Main sequence
    initial begin
        reset_n = 1'b0;
        pushButton_n = 1'b1;
        supplyOn = 1'b0;
        offArm = 1'b1;
        holdCapFitted = 1'b0;
        respond = 1'b0;
        oscEn = 1'b0;
        glitch = 1'b0;
        cyc(5);
        reset_n = 1'b1;
        chk_state(1'b0);
        cyc(60);
        chk_state(1'b0);
        foreach (rows[i]) begin
            if (enHi !== 1'b1) begin
                cyc(60);
                press(5);
                cyc(10);
                `CHK(enHi, 1'b1)
            end
            holdCapFitted = rows[i].cap;
            oscEn = rows[i].cap;
            respond = rows[i].resp;
            press(rows[i].press);
            cyc(200);
            chk_state(rows[i].expOn);
        end
        respond = 1'b0;
        cyc(60);
        press(5);
        cyc(10);
        glitch = 1'b1;
        cyc(1);
        glitch = 1'b0;
        cyc(200);
        chk_state(1'b1);
        reset_n = 1'b0;
        supplyOn = 1'b1;
        cyc(5);
        reset_n = 1'b1;
        cyc(60);
        chk_state(1'b1);
        supplyOn = 1'b0;
        cyc(8);
        `CHK(irqHi, 1'b0)
        cyc(40);
        chk_state(1'b0);
        press(5);
        cyc(5);
        chk_state(1'b0);
        cyc(50);
        supplyOn = 1'b1;
        cyc(10);
        chk_state(1'b1);
        offArm = 1'b0;
        supplyOn = 1'b0;
        cyc(40);
        chk_state(1'b1);
        close_out();
    end
endmodule
`default_nettype wire
